// *** hw/cjrc_top.sv ***
// cipher job register control: key, address and count registers plus two data memories
//
// Summary of operation
// R1: processor writes key words, low word last
// R2: low decrypt key write pulses load strobe
// R3: decrypt command reads nonzero during key setup
// R4: command read gives remaining count and busy
// R5: finished means whole command register reads zero
// R6: processor resets start addresses before count
// R7: count write starts a job of blocks
// R8: encrypt and decrypt have own command registers
// R9: plain memory readable and writable via window
// R10: cipher memory readable and writable via window
// R11: processor fills window offsets 0x0000..0x07FF
// R12: processor limits readback to memory size
// R13: key setup completes in ten cycles
// R14: low encrypt key write pulses load strobe
// R15: each fed block advances address, decrements count
// R16: upper key word writes only store value
// R17: busy holds until last block is stored
`timescale 1ns/1ns
`include "cjrc_consts.svh"
module cjrc_top
  import cjrc_pkg::*;
#(
  parameter int MEM_DEPTH = `CJRC_MEM_DEPTH
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [`CJRC_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wr_data,
  output logic [31:0] o_reg_rd_data,
  output logic o_reg_rd_valid,
  output logic [127:0] o_enc_key,
  output logic o_enc_key_load_strobe,
  output logic [127:0] o_dec_key,
  output logic o_dec_key_load_strobe,
  output logic [127:0] o_enc_data,
  output logic o_enc_data_valid,
  input wire logic i_enc_in_finish,
  input wire logic [127:0] i_enc_out_data,
  input wire logic i_enc_out_valid,
  output logic [127:0] o_dec_data,
  output logic o_dec_data_valid,
  input wire logic i_dec_in_finish,
  input wire logic [127:0] i_dec_out_data,
  input wire logic i_dec_out_valid
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int CW = `CJRC_CNT_W;

  logic [127:0] plain_data_memory [MEM_DEPTH];
  logic [127:0] cipher_data_memory [MEM_DEPTH];
  logic [AW-1:0] plain_addr_q, plain_addr_d;
  logic [AW-1:0] cipher_addr_q, cipher_addr_d;
  logic [127:0] enc_key_q, enc_key_d, dec_key_q, dec_key_d;
  logic enc_strobe_q, enc_strobe_d, dec_strobe_q, dec_strobe_d;
  logic [127:0] enc_data_q, enc_data_d, dec_data_q, dec_data_d;
  logic enc_valid_q, enc_valid_d, dec_valid_q, dec_valid_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic rd_valid_q, rd_valid_d;
  logic plain_we, cipher_we;
  logic [AW-1:0] plain_idx, cipher_idx;
  logic [127:0] plain_wdata, cipher_wdata;
  logic enc_feed, enc_busy, dec_feed, dec_busy;
  logic [CW-1:0] enc_rem, dec_rem;
  logic enc_count_wr, dec_count_wr;
  logic [AW-1:0] win_idx;
  logic [1:0] win_lane;

  function automatic logic reg_hit(input logic [`CJRC_ADDR_W-1:0] a,
                                   input logic [`CJRC_ADDR_W-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  function automatic logic win_hit(input logic [`CJRC_ADDR_W-1:0] a,
                                   input logic [`CJRC_ADDR_W-1:0] base);
    win_hit = (a >> `CJRC_WIN_SHIFT) == (base >> `CJRC_WIN_SHIFT);
  endfunction : win_hit

  function automatic logic [127:0] put_lane(input logic [127:0] entry,
                                            input logic [1:0] lane,
                                            input logic [31:0] word);
    logic [127:0] r;
    r = entry;
    r[32*lane +: 32] = word;
    put_lane = r;
  endfunction : put_lane

  function automatic logic [31:0] status_word(input logic busy, input logic [CW-1:0] rem);
    logic [31:0] s;
    s = '0;
    s[CW-1:0] = rem;
    s[`CJRC_BUSY_BIT] = busy;
    status_word = s;
  endfunction : status_word

  assign win_idx = AW'(i_reg_addr[`CJRC_WIN_SHIFT-1:4]);
  assign win_lane = i_reg_addr[3:2];
  assign enc_count_wr = i_reg_wr_en && reg_hit(i_reg_addr, `CJRC_ENC_COUNT_OFS);
  assign dec_count_wr = i_reg_wr_en && reg_hit(i_reg_addr, `CJRC_DEC_COUNT_OFS);

  cjrc_job #(.CNT_W(CW), .KEY_CYCLES(`CJRC_KEY_SETUP_CYCLES)) u_enc_job (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_key_load(enc_strobe_q),
    .i_count_wr(enc_count_wr),
    .i_count_data(i_reg_wr_data[CW-1:0]),
    .i_start_ok(!dec_busy),
    .i_in_finish(i_enc_in_finish),
    .i_out_valid(i_enc_out_valid),
    .o_feed(enc_feed),
    .o_busy(enc_busy),
    .o_remaining(enc_rem)
  );

  cjrc_job #(.CNT_W(CW), .KEY_CYCLES(`CJRC_KEY_SETUP_CYCLES)) u_dec_job (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_key_load(dec_strobe_q),
    .i_count_wr(dec_count_wr),
    .i_count_data(i_reg_wr_data[CW-1:0]),
    .i_start_ok(!enc_busy),
    .i_in_finish(i_dec_in_finish),
    .i_out_valid(i_dec_out_valid),
    .o_feed(dec_feed),
    .o_busy(dec_busy),
    .o_remaining(dec_rem)
  );

  // register writes, key strobes, address pointers and block feed
  always_comb
  begin
    enc_key_d = enc_key_q;
    dec_key_d = dec_key_q;
    enc_strobe_d = 1'b0;
    dec_strobe_d = 1'b0;
    plain_addr_d = plain_addr_q;
    cipher_addr_d = cipher_addr_q;
    if (i_reg_wr_en)
    begin
      case (i_reg_addr)
        `CJRC_PLAIN_START_OFS: plain_addr_d = i_reg_wr_data[AW-1:0];
        `CJRC_CIPHER_START_OFS: cipher_addr_d = i_reg_wr_data[AW-1:0];
        `CJRC_ENC_KEY_LOW_OFS:
        begin
          enc_key_d[31:0] = i_reg_wr_data;
          enc_strobe_d = 1'b1;                          // [R14]
        end
        `CJRC_ENC_KEY_SECOND_OFS: enc_key_d[63:32] = i_reg_wr_data;   // [R16]
        `CJRC_ENC_KEY_THIRD_OFS: enc_key_d[95:64] = i_reg_wr_data;    // [R16]
        `CJRC_ENC_KEY_HIGH_OFS: enc_key_d[127:96] = i_reg_wr_data;    // [R16]
        `CJRC_DEC_KEY_LOW_OFS:
        begin
          dec_key_d[31:0] = i_reg_wr_data;
          dec_strobe_d = 1'b1;                          // [R2]
        end
        `CJRC_DEC_KEY_SECOND_OFS: dec_key_d[63:32] = i_reg_wr_data;   // [R16]
        `CJRC_DEC_KEY_THIRD_OFS: dec_key_d[95:64] = i_reg_wr_data;    // [R16]
        `CJRC_DEC_KEY_HIGH_OFS: dec_key_d[127:96] = i_reg_wr_data;    // [R16]
        default: ;
      endcase
    end
    // encrypt reads plain and stores cipher; decrypt the reverse
    if (enc_feed || i_dec_out_valid)
      plain_addr_d = plain_addr_q + AW'(1);             // [R15]
    if (dec_feed || i_enc_out_valid)
      cipher_addr_d = cipher_addr_q + AW'(1);           // [R15]
    enc_data_d = enc_feed ? plain_data_memory[plain_addr_q] : enc_data_q;
    enc_valid_d = enc_feed;
    dec_data_d = dec_feed ? cipher_data_memory[cipher_addr_q] : dec_data_q;
    dec_valid_d = dec_feed;
  end

  // memory write ports: core results win over a processor write in the same cycle
  always_comb
  begin
    plain_we = 1'b0;
    plain_idx = win_idx;
    plain_wdata = put_lane(plain_data_memory[win_idx], win_lane, i_reg_wr_data);
    cipher_we = 1'b0;
    cipher_idx = win_idx;
    cipher_wdata = put_lane(cipher_data_memory[win_idx], win_lane, i_reg_wr_data);
    if (i_dec_out_valid)
    begin
      plain_we = 1'b1;                                  // [R17]
      plain_idx = plain_addr_q;
      plain_wdata = i_dec_out_data;
    end
    else if (i_reg_wr_en && win_hit(i_reg_addr, `CJRC_PLAIN_BASE))
      plain_we = 1'b1;                                  // [R9]
    if (i_enc_out_valid)
    begin
      cipher_we = 1'b1;                                 // [R17]
      cipher_idx = cipher_addr_q;
      cipher_wdata = i_enc_out_data;
    end
    else if (i_reg_wr_en && win_hit(i_reg_addr, `CJRC_CIPHER_BASE))
      cipher_we = 1'b1;                                 // [R10]
  end

  // read answers one cycle after the request
  always_comb
  begin
    rd_valid_d = i_reg_rd_en;
    rd_data_d = '0;
    if (i_reg_rd_en)
    begin
      if (win_hit(i_reg_addr, `CJRC_PLAIN_BASE))
        rd_data_d = plain_data_memory[win_idx][32*win_lane +: 32];   // [R9]
      else if (win_hit(i_reg_addr, `CJRC_CIPHER_BASE))
        rd_data_d = cipher_data_memory[win_idx][32*win_lane +: 32];  // [R10]
      else
      begin
        case (i_reg_addr)
          `CJRC_PLAIN_START_OFS: rd_data_d = 32'(plain_addr_q);
          `CJRC_CIPHER_START_OFS: rd_data_d = 32'(cipher_addr_q);
          `CJRC_ENC_COUNT_OFS: rd_data_d = status_word(enc_busy, enc_rem);  // [R4] [R5]
          `CJRC_DEC_COUNT_OFS: rd_data_d = status_word(dec_busy, dec_rem);  // [R3] [R4]
          `CJRC_ENC_KEY_LOW_OFS: rd_data_d = enc_key_q[31:0];
          `CJRC_ENC_KEY_SECOND_OFS: rd_data_d = enc_key_q[63:32];
          `CJRC_ENC_KEY_THIRD_OFS: rd_data_d = enc_key_q[95:64];
          `CJRC_ENC_KEY_HIGH_OFS: rd_data_d = enc_key_q[127:96];
          `CJRC_DEC_KEY_LOW_OFS: rd_data_d = dec_key_q[31:0];
          `CJRC_DEC_KEY_SECOND_OFS: rd_data_d = dec_key_q[63:32];
          `CJRC_DEC_KEY_THIRD_OFS: rd_data_d = dec_key_q[95:64];
          `CJRC_DEC_KEY_HIGH_OFS: rd_data_d = dec_key_q[127:96];
          default: rd_data_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (plain_we)
      plain_data_memory[plain_idx] <= plain_wdata;
    if (cipher_we)
      cipher_data_memory[cipher_idx] <= cipher_wdata;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      plain_addr_q <= '0;
      cipher_addr_q <= '0;
      enc_key_q <= '0;
      dec_key_q <= '0;
      enc_strobe_q <= 1'b0;
      dec_strobe_q <= 1'b0;
      enc_data_q <= '0;
      dec_data_q <= '0;
      enc_valid_q <= 1'b0;
      dec_valid_q <= 1'b0;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      plain_addr_q <= plain_addr_d;
      cipher_addr_q <= cipher_addr_d;
      enc_key_q <= enc_key_d;
      dec_key_q <= dec_key_d;
      enc_strobe_q <= enc_strobe_d;
      dec_strobe_q <= dec_strobe_d;
      enc_data_q <= enc_data_d;
      dec_data_q <= dec_data_d;
      enc_valid_q <= enc_valid_d;
      dec_valid_q <= dec_valid_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign o_reg_rd_data = rd_data_q;
  assign o_reg_rd_valid = rd_valid_q;
  assign o_enc_key = enc_key_q;
  assign o_enc_key_load_strobe = enc_strobe_q;
  assign o_dec_key = dec_key_q;
  assign o_dec_key_load_strobe = dec_strobe_q;
  assign o_enc_data = enc_data_q;
  assign o_enc_data_valid = enc_valid_q;
  assign o_dec_data = dec_data_q;
  assign o_dec_data_valid = dec_valid_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_dec_strobe;
    (i_reg_wr_en && i_reg_addr == `CJRC_DEC_KEY_LOW_OFS)
      |=> o_dec_key_load_strobe && o_dec_key[31:0] == $past(i_reg_wr_data) ##1
      (!o_dec_key_load_strobe ||
       $past(i_reg_wr_en) && $past(i_reg_addr) == `CJRC_DEC_KEY_LOW_OFS);
  endproperty
  a_dec_strobe: assert property (p_dec_strobe) else $error("decrypt key strobe wrong"); // [R2]
  property p_enc_strobe;
    (i_reg_wr_en && i_reg_addr == `CJRC_ENC_KEY_LOW_OFS) |=> o_enc_key_load_strobe;
  endproperty
  a_enc_strobe: assert property (p_enc_strobe) else $error("encrypt key strobe missing"); // [R14]
  property p_upper_quiet;
    (i_reg_wr_en && (i_reg_addr == `CJRC_DEC_KEY_HIGH_OFS || i_reg_addr == `CJRC_ENC_KEY_HIGH_OFS))
      |=> !o_dec_key_load_strobe && !o_enc_key_load_strobe;
  endproperty
  a_upper_quiet: assert property (p_upper_quiet) else $error("upper key word fired strobe"); // [R16]
  property p_status_read;
    (i_reg_rd_en && i_reg_addr == `CJRC_DEC_COUNT_OFS)
      |=> o_reg_rd_valid && o_reg_rd_data == {24'h000000, $past(dec_busy), $past(dec_rem)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("command read wrong"); // [R4]
  property p_feed_addr;
    enc_feed |=> o_enc_data_valid && plain_addr_q == $past(plain_addr_q) + AW'(1);
  endproperty
  a_feed_addr: assert property (p_feed_addr) else $error("feed did not advance address"); // [R15]
endmodule : cjrc_top

// *** common/cjrc_consts.svh ***
// register offsets, window decode and timing counts for the cipher job register control
`ifndef CJRC_CONSTS_SVH
`define CJRC_CONSTS_SVH

`define CJRC_ADDR_W 16
`define CJRC_PLAIN_START_OFS 16'h0000
`define CJRC_CIPHER_START_OFS 16'h0004
`define CJRC_ENC_COUNT_OFS 16'h0008
`define CJRC_DEC_COUNT_OFS 16'h000C
`define CJRC_ENC_KEY_LOW_OFS 16'h0030
`define CJRC_ENC_KEY_SECOND_OFS 16'h0034
`define CJRC_ENC_KEY_THIRD_OFS 16'h0038
`define CJRC_ENC_KEY_HIGH_OFS 16'h003C
`define CJRC_DEC_KEY_LOW_OFS 16'h0040
`define CJRC_DEC_KEY_SECOND_OFS 16'h0044
`define CJRC_DEC_KEY_THIRD_OFS 16'h0048
`define CJRC_DEC_KEY_HIGH_OFS 16'h004C
`define CJRC_PLAIN_BASE 16'h2000
`define CJRC_CIPHER_BASE 16'h4000
`define CJRC_WIN_SHIFT 11
`define CJRC_CNT_W 7
`define CJRC_BUSY_BIT 7
`define CJRC_KEY_SETUP_CYCLES 10
`define CJRC_MEM_DEPTH 128

`endif

// *** common/cjrc_pkg.sv ***
// types shared by the cipher job register control modules
package cjrc_pkg;
  typedef enum logic [1:0] {
    CJRC_ST_IDLE = 2'b00,
    CJRC_ST_KEY = 2'b01,
    CJRC_ST_RUN = 2'b10
  } cjrc_state_e;
endpackage : cjrc_pkg

// *** hw/cjrc_job.sv ***
// one cipher job sequencer: key setup timing, block feed and busy tracking
`timescale 1ns/1ns
`include "cjrc_consts.svh"
module cjrc_job
  import cjrc_pkg::*;
#(
  parameter int CNT_W = `CJRC_CNT_W,
  parameter int KEY_CYCLES = `CJRC_KEY_SETUP_CYCLES
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_key_load,
  input wire logic i_count_wr,
  input wire logic [CNT_W-1:0] i_count_data,
  input wire logic i_start_ok,
  input wire logic i_in_finish,
  input wire logic i_out_valid,
  output logic o_feed,
  output logic o_busy,
  output logic [CNT_W-1:0] o_remaining
);
  cjrc_state_e state_q, state_d;
  logic [3:0] key_cnt_q, key_cnt_d;
  logic [CNT_W-1:0] rem_q, rem_d;
  logic [CNT_W-1:0] inflight_q, inflight_d;
  logic feed_q, feed_d;

  always_comb
  begin
    state_d = state_q;
    key_cnt_d = key_cnt_q;
    rem_d = rem_q;
    feed_d = 1'b0;
    inflight_d = inflight_q;
    case (state_q)
      CJRC_ST_IDLE:
      begin
        if (i_key_load)
        begin
          state_d = CJRC_ST_KEY;                        // [R3]
          key_cnt_d = 4'(KEY_CYCLES - 1);               // [R13]
        end
        else if (i_count_wr && i_start_ok && i_count_data != '0)
        begin
          state_d = CJRC_ST_RUN;                        // [R7]
          feed_d = 1'b1;
          rem_d = i_count_data - CNT_W'(1);
        end
      end
      CJRC_ST_KEY:
      begin
        if (key_cnt_q == 4'h0)
          state_d = CJRC_ST_IDLE;                       // [R13]
        else
          key_cnt_d = key_cnt_q - 4'h1;
      end
      CJRC_ST_RUN:
      begin
        if (i_in_finish && rem_q != '0)
        begin
          feed_d = 1'b1;                                // [R15]
          rem_d = rem_q - CNT_W'(1);
        end
        else if (rem_q == '0 && inflight_q == '0 && !feed_q)
          state_d = CJRC_ST_IDLE;                       // [R17]
      end
      default: state_d = CJRC_ST_IDLE;
    endcase
    if (feed_d && !i_out_valid)
      inflight_d = inflight_q + CNT_W'(1);
    else if (!feed_d && i_out_valid && inflight_q != '0)
      inflight_d = inflight_q - CNT_W'(1);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      state_q <= CJRC_ST_IDLE;
      key_cnt_q <= 4'h0;
      rem_q <= '0;
      inflight_q <= '0;
      feed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      key_cnt_q <= key_cnt_d;
      rem_q <= rem_d;
      inflight_q <= inflight_d;
      feed_q <= feed_d;
    end
  end

  assign o_feed = feed_q;
  assign o_busy = (state_q != CJRC_ST_IDLE);
  assign o_remaining = rem_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_key_busy;
    o_busy [*8] ##1 o_busy ##1 o_busy;
  endsequence
  property p_key_ten;
    (i_key_load && state_q == CJRC_ST_IDLE) |=> s_key_busy ##1 !o_busy;
  endproperty
  a_key_ten: assert property (p_key_ten) else $error("key setup not ten cycles"); // [R13]
  property p_key_busy;
    (state_q == CJRC_ST_KEY) |-> o_busy && o_remaining == '0;
  endproperty
  a_key_busy: assert property (p_key_busy) else $error("key setup not busy"); // [R3]
  property p_start;
    (state_q == CJRC_ST_IDLE && !i_key_load && i_count_wr && i_start_ok && i_count_data != '0)
      |=> o_feed && o_busy && o_remaining == $past(i_count_data) - CNT_W'(1);
  endproperty
  a_start: assert property (p_start) else $error("count write did not start job"); // [R7]
  property p_feed_step;
    (state_q == CJRC_ST_RUN && i_in_finish && rem_q != '0)
      |=> o_feed && o_remaining == $past(rem_q) - CNT_W'(1);
  endproperty
  a_feed_step: assert property (p_feed_step) else $error("feed did not count down"); // [R15]
  property p_no_feed_at_zero;
    (state_q == CJRC_ST_RUN && rem_q == '0) |=> !o_feed;
  endproperty
  a_no_feed_at_zero: assert property (p_no_feed_at_zero) else $error("feed past zero"); // [R15]
  property p_busy_inflight;
    (inflight_q != '0) |-> o_busy ##1 o_busy;
  endproperty
  a_busy_inflight: assert property (p_busy_inflight) else $error("idle with block pending"); // [R17]
  property p_idle_zero;
    !o_busy |-> o_remaining == '0 && inflight_q == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle with work left"); // [R5]
endmodule : cjrc_job

// *** verification/cjrc_core_model.sv ***
// behavioural cipher core that answers each fed block after a fixed latency
`timescale 1ns/1ns
module cjrc_core_model
#(
  parameter int LAT = 5,
  parameter logic [127:0] MASK = '0
)(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_data_valid,
  input wire logic [127:0] i_data,
  output logic o_in_finish,
  output logic o_out_valid,
  output logic [127:0] o_out_data
);
  int cnt;
  logic [127:0] held;
  // result bus shows the inverse of the held block outside its valid cycle
  assign o_out_data = o_out_valid ? held : ~held;
  always @(posedge i_core_clk)
  begin
    o_in_finish <= 1'h0;
    o_out_valid <= 1'h0;
    if (!i_resetn)
    begin
      cnt <= 0;
      held <= '0;
    end
    else if (i_data_valid)
    begin
      held <= i_data ^ MASK;
      cnt <= LAT;
    end
    else if (cnt == 1)
    begin
      o_out_valid <= 1'h1;
      o_in_finish <= 1'h1;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : cjrc_core_model

// *** verification/cipher_job_register_control_tb.sv ***
// self-checking testbench of the cipher job register control
`timescale 1ns/1ns
`include "cjrc_consts.svh"
module cipher_job_register_control_tb;
  localparam logic [127:0] ENC_MASK = {4{32'hA5A5A5A5}};
  localparam logic [127:0] DEC_MASK = {4{32'h3C3C3C3C}};
  logic core_clk, resetn, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [15:0] reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data;
  logic [127:0] enc_key, dec_key, enc_data, dec_data, enc_out_data, dec_out_data;
  logic enc_key_stb, dec_key_stb, enc_data_valid, dec_data_valid;
  logic enc_in_finish, dec_in_finish, enc_out_valid, dec_out_valid;
  int n_fail, num_checks, cyc, n_enc_stb, n_dec_stb, n_enc_feed, n_dec_feed;

  cjrc_top dut (.i_core_clk(core_clk), .i_resetn(resetn), .i_reg_wr_en(reg_wr_en),
    .i_reg_rd_en(reg_rd_en), .i_reg_addr(reg_addr), .i_reg_wr_data(reg_wr_data),
    .o_reg_rd_data(reg_rd_data), .o_reg_rd_valid(reg_rd_valid), .o_enc_key(enc_key),
    .o_enc_key_load_strobe(enc_key_stb), .o_dec_key(dec_key),
    .o_dec_key_load_strobe(dec_key_stb), .o_enc_data(enc_data),
    .o_enc_data_valid(enc_data_valid), .i_enc_in_finish(enc_in_finish),
    .i_enc_out_data(enc_out_data), .i_enc_out_valid(enc_out_valid), .o_dec_data(dec_data),
    .o_dec_data_valid(dec_data_valid), .i_dec_in_finish(dec_in_finish),
    .i_dec_out_data(dec_out_data), .i_dec_out_valid(dec_out_valid));
  cjrc_core_model #(.LAT(5), .MASK(ENC_MASK)) u_enc_core (.i_core_clk(core_clk),
    .i_resetn(resetn), .i_data_valid(enc_data_valid), .i_data(enc_data),
    .o_in_finish(enc_in_finish), .o_out_valid(enc_out_valid), .o_out_data(enc_out_data));
  cjrc_core_model #(.LAT(7), .MASK(DEC_MASK)) u_dec_core (.i_core_clk(core_clk),
    .i_resetn(resetn), .i_data_valid(dec_data_valid), .i_data(dec_data),
    .o_in_finish(dec_in_finish), .o_out_valid(dec_out_valid), .o_out_data(dec_out_data));

  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // pulse counters and the hang limit
  always @(posedge core_clk)
  begin
    cyc++;
    if (enc_key_stb === 1'h1) n_enc_stb++;
    if (dec_key_stb === 1'h1) n_dec_stb++;
    if (enc_data_valid === 1'h1) n_enc_feed++;
    if (dec_data_valid === 1'h1) n_dec_feed++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'h1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'h0;
  endtask : wr

  task rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd_en <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'h0;
    @(negedge core_clk);
    check("read answer", reg_rd_valid, 1'h1);
    d = reg_rd_data;
  endtask : rd

  task wr128(input logic [15:0] base, input int i, input logic [127:0] d);
    for (int l = 0; l < 4; l++) wr(16'(base + i * 16 + l * 4), d[32 * l +: 32]);
  endtask : wr128

  task rd128(input logic [15:0] base, input int i, output logic [127:0] d);
    logic [31:0] w;
    for (int l = 0; l < 4; l++)
    begin
      rd(16'(base + i * 16 + l * 4), w);
      d[32 * l +: 32] = w;
    end
  endtask : rd128

  function automatic logic [127:0] pat(input int i);
    return {32'(i), 32'h12340000 + 32'(i), ~32'(i), 32'hC3C30000 ^ 32'(i)};
  endfunction : pat

  task t_reset();
    logic [31:0] r;
    rd(`CJRC_ENC_COUNT_OFS, r);
    check("encrypt status after reset", r, 0);
    rd(`CJRC_DEC_COUNT_OFS, r);
    check("decrypt status after reset", r, 0);
    rd(16'h1000, r);
    check("unmapped read", r, 0);
    check("encrypt key after reset", enc_key, 0);
    check("decrypt key after reset", dec_key, 0);
  endtask : t_reset

  task t_key(input logic dec);
    logic [15:0] b, cmd;
    logic [127:0] k;
    int s0, nb;
    b = dec ? `CJRC_DEC_KEY_LOW_OFS : `CJRC_ENC_KEY_LOW_OFS;
    cmd = dec ? `CJRC_DEC_COUNT_OFS : `CJRC_ENC_COUNT_OFS;
    k = dec ? 128'hFFEEDDCCBBAA99887766554433221100 : 128'h00112233445566778899AABBCCDDEEFF;
    s0 = dec ? n_dec_stb : n_enc_stb;
    nb = 0;
    for (int w = 3; w > 0; w--) wr(16'(b + w * 4), k[32 * w +: 32]);
    // second falling edge lets the pulse counter see a strobe from the last upper write
    repeat (2) @(negedge core_clk);
    check("upper key words", dec ? dec_key[127:32] : enc_key[127:32], k[127:32]);
    check("no strobe on upper words", dec ? n_dec_stb : n_enc_stb, s0);
    wr(b, k[31:0]);
    reg_rd_en <= 1'h1;
    reg_addr <= cmd;
    @(negedge core_clk);
    check("key load strobe", dec ? dec_key_stb : enc_key_stb, 1'h1);
    // status read on every edge across the whole setup window
    for (int i = 0; i < 14; i++)
    begin
      @(posedge core_clk);
      if (i == 13) reg_rd_en <= 1'h0;
      @(negedge core_clk);
      if (reg_rd_valid === 1'h1 && reg_rd_data[7] === 1'h1) nb++;
    end
    check("key value", dec ? dec_key : enc_key, k);
    check("one strobe", (dec ? n_dec_stb : n_enc_stb) - s0, 1);
    if (dec) check("setup busy cycles", nb, 10);
    check("status after setup", reg_rd_data, 0);
  endtask : t_key

  task t_window();
    logic [127:0] d;
    wr128(`CJRC_PLAIN_BASE, `CJRC_MEM_DEPTH - 1, 128'hDEADBEEF0BADF00D1357924680ACE135);
    wr128(`CJRC_CIPHER_BASE, `CJRC_MEM_DEPTH - 1, 128'h55AA33CC0FF0F00F9669699612345678);
    rd128(`CJRC_PLAIN_BASE, `CJRC_MEM_DEPTH - 1, d);
    check("plain window", d, 128'hDEADBEEF0BADF00D1357924680ACE135);
    rd128(`CJRC_CIPHER_BASE, `CJRC_MEM_DEPTH - 1, d);
    check("cipher window", d, 128'h55AA33CC0FF0F00F9669699612345678);
  endtask : t_window

  task t_job(input logic dec, input int n);
    logic [15:0] src, dst, cmd, other;
    logic [127:0] d;
    logic [31:0] r;
    int f0, o0, np;
    src = dec ? `CJRC_CIPHER_BASE : `CJRC_PLAIN_BASE;
    dst = dec ? `CJRC_PLAIN_BASE : `CJRC_CIPHER_BASE;
    cmd = dec ? `CJRC_DEC_COUNT_OFS : `CJRC_ENC_COUNT_OFS;
    other = dec ? `CJRC_ENC_COUNT_OFS : `CJRC_DEC_COUNT_OFS;
    np = 0;
    for (int i = 0; i < n; i++) wr128(src, i, pat(i));
    wr(`CJRC_PLAIN_START_OFS, 0);
    wr(`CJRC_CIPHER_START_OFS, 0);
    wr(cmd, 0);
    rd(cmd, r);
    check("zero count ignored", r, 0);
    f0 = dec ? n_dec_feed : n_enc_feed;
    o0 = dec ? n_enc_feed : n_dec_feed;
    wr(cmd, 32'(n));
    wr(other, 1);
    rd(cmd, r);
    check("busy after start", r[7], 1'h1);
    while (r !== 0 && np < 3000)
    begin
      rd(cmd, r);
      np++;
    end
    check("job finished", r, 0);
    check("blocks fed", (dec ? n_dec_feed : n_enc_feed) - f0, n);
    check("second job refused", (dec ? n_enc_feed : n_dec_feed) - o0, 0);
    for (int i = 0; i < n && i < `CJRC_MEM_DEPTH; i++)
    begin
      rd128(dst, i, d);
      check("stored result", d, pat(i) ^ (dec ? DEC_MASK : ENC_MASK));
    end
  endtask : t_job

  initial
  begin
    resetn = 1'h0;
    reg_wr_en = 1'h0;
    reg_rd_en = 1'h0;
    reg_addr = '0;
    reg_wr_data = '0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset();
    t_key(1'h0);
    t_key(1'h1);
    t_window();
    t_job(1'h0, 3);
    t_job(1'h1, 127);
    finish_test();
  end
endmodule : cipher_job_register_control_tb
